// ---- verilog/banked_mem_pkg.sv ----
// constants for the banked data memory and core status register
package banked_mem_pkg;
  localparam int ADDR_W = 9;
  localparam int FILE_W = 7;
  localparam int BANK_COUNT = 4;
  localparam int SFR_SIZE = 32;
  localparam logic [6:0] OFS_INDIRECT_DATA_PORT = 7'h00;
  localparam logic [6:0] OFS_PROGRAM_COUNTER_LOW = 7'h02;
  localparam logic [6:0] OFS_STATUS = 7'h03;
  localparam logic [6:0] OFS_INDIRECT_POINTER = 7'h04;
  localparam logic [6:0] OFS_PROGRAM_COUNTER_LATCH_HIGH = 7'h0a;
  localparam logic [6:0] OFS_INTERRUPT_CONTROL = 7'h0b;
  localparam logic [6:0] GPR0_LO = 7'h20;
  localparam logic [6:0] GPR0_HI = 7'h7f;
  localparam logic [6:0] GPRN_LO = 7'h20;
  localparam logic [6:0] GPRN_HI = 7'h6f;
  localparam int GPR0_SIZE = 96;
  localparam int GPRN_SIZE = 80;
  localparam int GPR_TOTAL = 336;
  localparam int BIT_IRP = 7;
  localparam int BIT_RP_HI = 6;
  localparam int BIT_RP_LO = 5;
  localparam int BIT_TO = 4;
  localparam int BIT_PD = 3;
  localparam int BIT_Z = 2;
  localparam int BIT_DC = 1;
  localparam int BIT_C = 0;
  localparam int NIBBLE = 4;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  typedef enum logic [3:0] {
    OP_NONE, OP_MOVE_IN, OP_MOVE_OUT, OP_ADD, OP_SUB, OP_LOGIC,
    OP_CLEAR, OP_ROTATE_RIGHT, OP_ROTATE_LEFT, OP_PASS
  } alu_op_t;
endpackage

// ---- verilog/data_addr_decode.sv ----
// address former and region decoder for the banked data memory
`timescale 1ns/1ps
`default_nettype none
module data_addr_decode (
  input wire logic indirect,
  input wire logic [6:0] file_addr,
  input wire logic [1:0] direct_bank_select,
  input wire logic indirect_bank_pair_select,
  input wire logic [7:0] indirect_pointer,
  output logic [8:0] full_addr,
  output logic is_sfr,
  output logic is_gpr,
  output logic [8:0] gpr_index
);
  logic [1:0] bank;
  logic [6:0] ofs;
  always_comb begin
    if (indirect) begin
      full_addr = {indirect_bank_pair_select, indirect_pointer};
    end else begin
      full_addr = {direct_bank_select, file_addr};
    end
    bank = full_addr[8:7];
    ofs = full_addr[6:0];
    is_sfr = (ofs < 7'(banked_mem_pkg::SFR_SIZE));
    is_gpr = 1'b0;
    gpr_index = 9'h000;
    if (bank == 2'b00) begin
      is_gpr = (ofs >= banked_mem_pkg::GPR0_LO);
      gpr_index = 9'(ofs - banked_mem_pkg::GPR0_LO);
    end else begin
      is_gpr = (ofs >= banked_mem_pkg::GPRN_LO) && (ofs <= banked_mem_pkg::GPRN_HI);
      gpr_index = 9'(banked_mem_pkg::GPR0_SIZE + (bank - 1) * banked_mem_pkg::GPRN_SIZE
                     + (ofs - banked_mem_pkg::GPRN_LO));
    end
  end
endmodule
`default_nettype wire

// ---- verilog/status_alu.sv ----
// alu and flag computation for one instruction
`timescale 1ns/1ps
`default_nettype none
module status_alu (
  input wire logic [3:0] op,
  input wire logic [7:0] acc,
  input wire logic [7:0] src,
  input wire logic [7:0] logic_result,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic sets_zero,
  output logic sets_carries,
  output logic sets_carry,
  output logic zero,
  output logic digit_carry,
  output logic carry
);
  logic [8:0] sum;
  logic [4:0] low;
  logic [7:0] addend;
  logic twos_carry;
  always_comb begin
    // subtract adds the inverted operand plus one, so both carries see the +1
    twos_carry = (op == banked_mem_pkg::OP_SUB);
    addend = twos_carry ? ~acc : acc;
    sum = {1'b0, src} + {1'b0, addend} + {8'h00, twos_carry};
    low = {1'b0, src[3:0]} + {1'b0, addend[3:0]} + {4'h0, twos_carry};
    result = src;
    sets_zero = 1'b0;
    sets_carries = 1'b0;
    sets_carry = 1'b0;
    carry = carry_in;
    digit_carry = 1'b0;
    unique case (op)
      banked_mem_pkg::OP_ADD, banked_mem_pkg::OP_SUB: begin
        result = sum[7:0];
        sets_zero = 1'b1;
        sets_carries = 1'b1;
        carry = sum[8];
        digit_carry = low[4];
      end
      banked_mem_pkg::OP_LOGIC: begin
        result = logic_result;
        sets_zero = 1'b1;
      end
      banked_mem_pkg::OP_CLEAR: begin
        result = banked_mem_pkg::ZERO_BYTE;
        sets_zero = 1'b1;
      end
      banked_mem_pkg::OP_ROTATE_RIGHT: begin
        result = {carry_in, src[7:1]};
        sets_carry = 1'b1;
        carry = src[0];
      end
      banked_mem_pkg::OP_ROTATE_LEFT: begin
        result = {src[6:0], carry_in};
        sets_carry = 1'b1;
        carry = src[7];
      end
      banked_mem_pkg::OP_MOVE_IN, banked_mem_pkg::OP_MOVE_OUT: begin
        result = (op == banked_mem_pkg::OP_MOVE_IN) ? src : acc;
        sets_zero = (op == banked_mem_pkg::OP_MOVE_IN);
      end
      default: result = src;
    endcase
    zero = (result == banked_mem_pkg::ZERO_BYTE);
  end
endmodule
`default_nettype wire

// ---- verilog/banked_data_memory_status.sv ----
// banked data memory with core registers and status register
// Function
// - data memory is four banks; lowest 32 addresses of each are special registers
// - general ram at 20-7F, A0-EF, 120-16F, 1A0-1EF
// - unimplemented addresses read as zero
// - status bits 6-5 pick the bank for direct access
// - status bit 7 picks bank pair for indirect access
// - indirect address is pointer plus bank-pair bit, reaching all memory
// - core registers mirrored at same offset in all four banks
// - flag-affecting op writing status keeps computed z, dc, c
// - timeout and power-down flags ignore register writes
// - clearing status gives 000u u1uu
// - timeout flag set by power-up, watchdog clear, sleep; cleared by timeout
// - power-down flag set by power-up, watchdog clear; cleared by sleep
// - zero flag follows whether result is zero
// - digit carry is carry out of bit 3 for add and subtract
// - carry is carry out of bit 7 for add and subtract
// - subtract adds two's complement, carries act as inverted borrow
// - rotates load carry from low or high source bit
// - file-to-file move goes through accumulator, taking two cycles
`timescale 1ns/1ps
`default_nettype none
module banked_data_memory_status #(
  parameter int GPR_DEPTH = banked_mem_pkg::GPR_TOTAL
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic op_valid,
  input wire logic [3:0] op,
  input wire logic indirect,
  input wire logic [6:0] file_addr,
  input wire logic dest_file,
  input wire logic [7:0] logic_result,
  input wire logic [7:0] program_counter_low_in,
  input wire logic [7:0] interrupt_control_in,
  input wire logic watchdog_clear_instruction,
  input wire logic sleep_instruction,
  input wire logic watchdog_timeout,
  output logic [7:0] read_data,
  output logic [7:0] accumulator,
  output logic [7:0] core_flags_and_bank_select,
  output logic [7:0] indirect_pointer,
  output logic [7:0] program_counter_latch_high,
  output logic [7:0] program_counter_low_wr,
  output logic program_counter_low_we,
  output logic [7:0] interrupt_control_wr,
  output logic interrupt_control_we
);
  logic [7:0] general_purpose_ram [GPR_DEPTH];
  logic [7:0] next_read_data, next_accumulator, next_status, next_pointer, next_latch;
  logic [7:0] next_pcl_wr, next_interrupt_control_wr, next_gpr_data;
  logic next_pcl_we, next_interrupt_control_we, next_gpr_we;
  logic [8:0] full_addr, gpr_index;
  logic is_sfr, is_gpr;
  logic [7:0] src, result;
  logic sets_zero, sets_carries, sets_carry, zero, digit_carry, carry;
  logic wr_file;

  ////////////////////////////////////////////////////////////////////////////
  // address decode and alu
  data_addr_decode u_decode (
    .indirect(indirect),
    .file_addr(file_addr),
    .direct_bank_select(core_flags_and_bank_select[banked_mem_pkg::BIT_RP_HI:
                                                   banked_mem_pkg::BIT_RP_LO]),
    .indirect_bank_pair_select(core_flags_and_bank_select[banked_mem_pkg::BIT_IRP]),
    .indirect_pointer(indirect_pointer),
    .full_addr(full_addr),
    .is_sfr(is_sfr),
    .is_gpr(is_gpr),
    .gpr_index(gpr_index)
  );

  status_alu u_alu (
    .op(op),
    .acc(accumulator),
    .src(src),
    .logic_result(logic_result),
    .carry_in(core_flags_and_bank_select[banked_mem_pkg::BIT_C]),
    .result(result),
    .sets_zero(sets_zero),
    .sets_carries(sets_carries),
    .sets_carry(sets_carry),
    .zero(zero),
    .digit_carry(digit_carry),
    .carry(carry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    src = banked_mem_pkg::ZERO_BYTE;
    if (is_sfr) begin
      unique case (full_addr[6:0])
        banked_mem_pkg::OFS_PROGRAM_COUNTER_LOW: src = program_counter_low_in;
        banked_mem_pkg::OFS_STATUS: src = core_flags_and_bank_select;
        banked_mem_pkg::OFS_INDIRECT_POINTER: src = indirect_pointer;
        banked_mem_pkg::OFS_PROGRAM_COUNTER_LATCH_HIGH: src = program_counter_latch_high;
        banked_mem_pkg::OFS_INTERRUPT_CONTROL: src = interrupt_control_in;
        default: src = banked_mem_pkg::ZERO_BYTE;
      endcase
    end else if (is_gpr && gpr_index < 9'(GPR_DEPTH)) begin
      src = general_purpose_ram[gpr_index];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_read_data = src;
    next_accumulator = accumulator;
    next_status = core_flags_and_bank_select;
    next_pointer = indirect_pointer;
    next_latch = program_counter_latch_high;
    next_pcl_wr = program_counter_low_wr;
    next_interrupt_control_wr = interrupt_control_wr;
    next_pcl_we = 1'b0;
    next_interrupt_control_we = 1'b0;
    next_gpr_we = 1'b0;
    next_gpr_data = result;
    wr_file = op_valid && (op != banked_mem_pkg::OP_NONE) &&
              (op == banked_mem_pkg::OP_MOVE_OUT || (dest_file &&
               op != banked_mem_pkg::OP_MOVE_IN));
    if (op_valid && !wr_file && op != banked_mem_pkg::OP_NONE) begin
      next_accumulator = result;
    end
    if (wr_file) begin
      if (is_sfr) begin
        unique case (full_addr[6:0])
          banked_mem_pkg::OFS_STATUS: begin
            next_status[banked_mem_pkg::BIT_IRP] = result[banked_mem_pkg::BIT_IRP];
            next_status[banked_mem_pkg::BIT_RP_HI] = result[banked_mem_pkg::BIT_RP_HI];
            next_status[banked_mem_pkg::BIT_RP_LO] = result[banked_mem_pkg::BIT_RP_LO];
            // timeout and power-down keep their value here
            if (!sets_zero && !sets_carries && !sets_carry) begin
              next_status[banked_mem_pkg::BIT_Z] = result[banked_mem_pkg::BIT_Z];
              next_status[banked_mem_pkg::BIT_DC] = result[banked_mem_pkg::BIT_DC];
              next_status[banked_mem_pkg::BIT_C] = result[banked_mem_pkg::BIT_C];
            end
          end
          banked_mem_pkg::OFS_INDIRECT_POINTER: next_pointer = result;
          banked_mem_pkg::OFS_PROGRAM_COUNTER_LATCH_HIGH: next_latch = result;
          banked_mem_pkg::OFS_PROGRAM_COUNTER_LOW: begin
            next_pcl_wr = result;
            next_pcl_we = 1'b1;
          end
          banked_mem_pkg::OFS_INTERRUPT_CONTROL: begin
            next_interrupt_control_wr = result;
            next_interrupt_control_we = 1'b1;
          end
          default: next_gpr_we = 1'b0;
        endcase
      end else if (is_gpr && gpr_index < 9'(GPR_DEPTH)) begin
        next_gpr_we = 1'b1;
      end
    end
    // computed flags win over the register write
    if (op_valid && sets_zero) next_status[banked_mem_pkg::BIT_Z] = zero;
    if (op_valid && sets_carries) begin
      next_status[banked_mem_pkg::BIT_DC] = digit_carry;
      next_status[banked_mem_pkg::BIT_C] = carry;
    end
    if (op_valid && sets_carry) next_status[banked_mem_pkg::BIT_C] = carry;
    // hardware-only flags, timeout event wins
    if (watchdog_clear_instruction) begin
      next_status[banked_mem_pkg::BIT_TO] = 1'b1;
      next_status[banked_mem_pkg::BIT_PD] = 1'b1;
    end
    if (sleep_instruction) begin
      next_status[banked_mem_pkg::BIT_TO] = 1'b1;
      next_status[banked_mem_pkg::BIT_PD] = 1'b0;
    end
    if (watchdog_timeout) next_status[banked_mem_pkg::BIT_TO] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      read_data <= banked_mem_pkg::ZERO_BYTE;
      accumulator <= banked_mem_pkg::ZERO_BYTE;
      core_flags_and_bank_select <= banked_mem_pkg::STATUS_RESET;
      indirect_pointer <= banked_mem_pkg::ZERO_BYTE;
      program_counter_latch_high <= banked_mem_pkg::ZERO_BYTE;
      program_counter_low_wr <= banked_mem_pkg::ZERO_BYTE;
      program_counter_low_we <= 1'b0;
      interrupt_control_wr <= banked_mem_pkg::ZERO_BYTE;
      interrupt_control_we <= 1'b0;
    end else begin
      read_data <= next_read_data;
      accumulator <= next_accumulator;
      core_flags_and_bank_select <= next_status;
      indirect_pointer <= next_pointer;
      program_counter_latch_high <= next_latch;
      program_counter_low_wr <= next_pcl_wr;
      program_counter_low_we <= next_pcl_we;
      interrupt_control_wr <= next_interrupt_control_wr;
      interrupt_control_we <= next_interrupt_control_we;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (next_gpr_we) general_purpose_ram[gpr_index] <= next_gpr_data;
  end
endmodule
`default_nettype wire

// ---- dv/pc_side_model.sv ----
// far-side model holding program counter low and interrupt control
`timescale 1ns/1ps
`default_nettype none
module pc_side_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] program_counter_low_wr,
  input wire logic program_counter_low_we,
  input wire logic [7:0] interrupt_control_wr,
  input wire logic interrupt_control_we,
  output logic [7:0] program_counter_low_in,
  output logic [7:0] interrupt_control_in
);
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      program_counter_low_in <= 8'h00;
      interrupt_control_in <= 8'h00;
    end else begin
      if (program_counter_low_we) program_counter_low_in <= program_counter_low_wr;
      if (interrupt_control_we) interrupt_control_in <= interrupt_control_wr;
    end
  end
endmodule
`default_nettype wire

// ---- dv/banked_mem_props.sv ----
// assertions on the banked data memory and status register ports
`timescale 1ns/1ps
`default_nettype none
module banked_mem_props (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic op_valid,
  input wire logic [3:0] op,
  input wire logic indirect,
  input wire logic [6:0] file_addr,
  input wire logic dest_file,
  input wire logic watchdog_clear_instruction,
  input wire logic sleep_instruction,
  input wire logic watchdog_timeout,
  input wire logic [7:0] read_data,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] core_flags_and_bank_select,
  input wire logic [7:0] program_counter_low_wr,
  input wire logic program_counter_low_we
);
  logic [7:0] st;
  logic [7:0] acc_prev;
  logic [8:0] add_sum;
  logic [8:0] sub_sum;
  logic [4:0] add_nib;
  logic [4:0] sub_nib;
  logic wdc;
  logic slp;
  logic tmo;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge sys_clk) begin
    acc_prev <= accumulator;
  end
  always_comb begin
    st = core_flags_and_bank_select;
    wdc = watchdog_clear_instruction;
    slp = sleep_instruction;
    tmo = watchdog_timeout;
    add_sum = {1'b0, read_data} + {1'b0, acc_prev};
    sub_sum = {1'b0, read_data} + {1'b0, ~acc_prev} + 9'h001;
    add_nib = {1'b0, read_data[3:0]} + {1'b0, acc_prev[3:0]};
    sub_nib = {1'b0, read_data[3:0]} + {1'b0, ~acc_prev[3:0]} + 5'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_add_carry: assert property (op_valid && op == banked_mem_pkg::OP_ADD && !dest_file
    |=> {st[0], accumulator} == add_sum && st[1] == add_nib[4]) else $error("add wrong");
  a_sub_borrow: assert property (op_valid && op == banked_mem_pkg::OP_SUB && !dest_file
    |=> {st[0], accumulator} == sub_sum && st[1] == sub_nib[4]) else $error("sub wrong");
  a_zero_flag: assert property (op_valid && !dest_file && op == banked_mem_pkg::OP_ADD
    |=> st[2] == (accumulator == 8'h00)) else $error("zero flag wrong");
  a_rotr_carry: assert property (op_valid && op == banked_mem_pkg::OP_ROTATE_RIGHT
    |=> st[0] == read_data[0]) else $error("rotate right carry wrong");
  a_rotl_carry: assert property (op_valid && op == banked_mem_pkg::OP_ROTATE_LEFT
    |=> st[0] == read_data[7]) else $error("rotate left carry wrong");
  a_timeout_clears: assert property (tmo |=> !st[4])
    else $error("timeout flag not cleared");
  a_sleep_flags: assert property (slp && !tmo |=> st[4:3] == 2'b10)
    else $error("sleep flags");
  a_wdclear_flags: assert property (wdc && !slp && !tmo
    |=> st[4:3] == 2'b11) else $error("watchdog clear flags");
  a_flags_locked: assert property (!wdc && !slp && !tmo
    |=> $stable(st[4:3])) else $error("timeout or power-down changed");
  a_pcl_forward: assert property (op_valid && op == banked_mem_pkg::OP_MOVE_OUT
    && !indirect && file_addr == 7'h02
    |=> program_counter_low_we && program_counter_low_wr == acc_prev)
    else $error("program counter low write lost");
  a_reset_value: assert property ($rose(reset_n) |-> st == 8'h18)
    else $error("status reset");
endmodule
bind banked_data_memory_status banked_mem_props u_props (.sys_clk, .reset_n, .op_valid, .op,
  .indirect, .file_addr, .dest_file, .watchdog_clear_instruction, .sleep_instruction,
  .watchdog_timeout, .read_data, .accumulator, .core_flags_and_bank_select,
  .program_counter_low_wr, .program_counter_low_we);
`default_nettype wire

// ---- dv/banked_data_memory_status_test.sv ----
// self-checking bench for the banked data memory and status register
`timescale 1ns/1ps
`default_nettype none
module banked_data_memory_status_test;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic op_valid = 1'b0, indirect = 1'b0, dest_file = 1'b0;
  logic watchdog_clear_instruction = 1'b0, sleep_instruction = 1'b0, watchdog_timeout = 1'b0;
  logic [3:0] op = 4'h0;
  logic [6:0] file_addr = 7'h00;
  logic [7:0] logic_result = 8'h00, read_data, accumulator, core_flags_and_bank_select, st;
  logic [7:0] indirect_pointer, program_counter_latch_high, program_counter_low_in;
  logic [7:0] interrupt_control_in, program_counter_low_wr, interrupt_control_wr;
  logic program_counter_low_we, interrupt_control_we;
  int errors = 0;
  int num_checks = 0;
  logic [8:0] tbl [12] = '{9'h020, 9'h07f, 9'h0a0, 9'h0ef, 9'h0f0, 9'h120, 9'h16f, 9'h1a0,
    9'h1ef, 9'h1f0, 9'h005, 9'h17f};
  logic [15:0] ar [6] = '{16'h0f01, 16'hff01, 16'h0505, 16'h0305, 16'h2010, 16'h0700};
  logic [4:0] pt [4] = '{5'b00101, 5'b10011, 5'b11010, 5'b10101};
  assign st = core_flags_and_bank_select;
  always #50 sys_clk = ~sys_clk;
  banked_data_memory_status DUT (.sys_clk, .reset_n, .op_valid, .op, .indirect, .file_addr,
    .dest_file, .logic_result, .program_counter_low_in, .interrupt_control_in,
    .watchdog_clear_instruction, .sleep_instruction, .watchdog_timeout, .read_data,
    .accumulator, .core_flags_and_bank_select, .indirect_pointer, .program_counter_latch_high,
    .program_counter_low_wr, .program_counter_low_we, .interrupt_control_wr,
    .interrupt_control_we);
  pc_side_model far_side (.sys_clk, .reset_n, .program_counter_low_wr, .program_counter_low_we,
    .interrupt_control_wr, .interrupt_control_we, .program_counter_low_in, .interrupt_control_in);
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic step(input logic [3:0] o, input logic [6:0] a, input logic ind,
                      input logic [7:0] v);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op <= o;
    file_addr <= a;
    indirect <= ind;
    dest_file <= (o == banked_mem_pkg::OP_CLEAR);
    logic_result <= v;
  endtask
  task automatic idle();
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    step(banked_mem_pkg::OP_LOGIC, 7'h00, 1'b0, v);
    step(banked_mem_pkg::OP_MOVE_OUT, a, 1'b0, 8'h00);
  endtask
  task automatic rd(input logic [6:0] a, input logic ind);
    step(banked_mem_pkg::OP_MOVE_IN, a, ind, 8'h00);
    idle();
  endtask
  task automatic pulse(input logic [2:0] p);
    @(posedge sys_clk);
    {watchdog_clear_instruction, sleep_instruction, watchdog_timeout} <= p;
    @(posedge sys_clk);
    {watchdog_clear_instruction, sleep_instruction, watchdog_timeout} <= 3'b000;
    #1;
  endtask
  function automatic logic [7:0] gpr_exp(input logic [8:0] a, input logic [7:0] v);
    return (a[6:0] >= 7'h20 && (a[8:7] == 2'b00 || a[6:0] <= 7'h6f)) ? v : 8'h00;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    close_out();
  end
  initial begin
    logic [8:0] s;
    logic [4:0] n;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1;
    check(st, 8'h18);
    for (int i = 0; i < 12; i++) begin
      wr(7'h03, {1'b0, tbl[i][8:7], 5'h00});
      wr(tbl[i][6:0], 8'h40 + 8'(i));
    end
    for (int i = 0; i < 12; i++) begin
      wr(7'h03, {1'b0, tbl[i][8:7], 5'h00});
      rd(tbl[i][6:0], 1'b0);
      check(read_data, gpr_exp(tbl[i], 8'h40 + 8'(i)));
    end
    $display("bank map test done");
    wr(7'h03, 8'h60);
    wr(7'h04, 8'ha0);
    wr(7'h0a, 8'h3c);
    wr(7'h02, 8'h55);
    wr(7'h0b, 8'h9a);
    wr(7'h03, 8'h80);
    idle();
    check({indirect_pointer, 3'b000}, {8'ha0, 3'b000});
    check(program_counter_latch_high, 8'h3c);
    rd(7'h02, 1'b0);
    check(read_data, 8'h55);
    rd(7'h0b, 1'b0);
    check(read_data, 8'h9a);
    rd(7'h00, 1'b1);
    check(read_data, 8'h47);
    wr(7'h03, 8'h00);
    wr(7'h04, 8'h20);
    rd(7'h00, 1'b1);
    check(read_data, 8'h40);
    $display("mirror and indirect test done");
    for (int i = 0; i < 6; i++) begin
      wr(7'h20, ar[i][15:8]);
      step(banked_mem_pkg::OP_LOGIC, 7'h00, 1'b0, ar[i][7:0]);
      step(i < 2 ? banked_mem_pkg::OP_ADD : banked_mem_pkg::OP_SUB, 7'h20, 1'b0, 8'h00);
      idle();
      s = {1'b0, ar[i][15:8]} + (i < 2 ? {1'b0, ar[i][7:0]} : {1'b0, ~ar[i][7:0]} + 9'h001);
      n = {1'b0, ar[i][11:8]} + (i < 2 ? {1'b0, ar[i][3:0]} : {1'b0, ~ar[i][3:0]} + 5'h01);
      check({st[2:0], accumulator}, {s[7:0] == 8'h00, n[4], s});
    end
    wr(7'h20, 8'h01);
    step(banked_mem_pkg::OP_ROTATE_RIGHT, 7'h20, 1'b0, 8'h00);
    step(banked_mem_pkg::OP_ROTATE_LEFT, 7'h20, 1'b0, 8'h00);
    #1;
    check(st[0], 1'b1);
    idle();
    check(st[0], 1'b0);
    $display("flag test done");
    for (int i = 0; i < 4; i++) begin
      pulse(pt[i][4:2]);
      check(st[4:3], pt[i][1:0]);
    end
    wr(7'h03, 8'hff);
    idle();
    check(st, 8'hef);
    step(banked_mem_pkg::OP_CLEAR, 7'h03, 1'b0, 8'h00);
    idle();
    check(st, 8'h0f);
    $display("status write test done");
    step(banked_mem_pkg::OP_MOVE_IN, 7'h7f, 1'b0, 8'h00);
    step(banked_mem_pkg::OP_MOVE_OUT, 7'h7e, 1'b0, 8'h00);
    rd(7'h7e, 1'b0);
    check(read_data, 8'h41);
    $display("move test done");
    close_out();
  end
endmodule
`default_nettype wire
